// File: dv/apc_adc_port_asserts.sv
// Concurrent checks on the pins of the converter port.
`timescale 1ns/1ps
`default_nettype none
module apc_adc_port_asserts
  import apc_pkg::*;
#(
  parameter int RES_BITS = 12
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rstn,
  // Host pins
  input wire logic              cs_n,
  input wire logic              rd_n,
  input wire logic              power_down_n,
  input wire logic              seq_access,
  // Outputs
  input wire logic [WORD_W-1:0] data_out,
  input wire logic [WORD_W-1:0] data_oe_n,
  input wire logic              busy,
  input wire logic              track_hold,
  input wire logic              conv_diff,
  input wire logic [2:0]        conv_mux_addr,
  input wire logic              shutdown_light,
  input wire logic              shutdown_deep
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_busy_span;
    !busy[*8] ##1 !busy[*3] ##1 busy;
  endsequence
  sequence s_hold_span;
    track_hold[*8] ##1 track_hold[*2] ##1 !track_hold;
  endsequence
  sequence s_conv_end;
    $rose(busy) && $past(track_hold, 3) && !$past(track_hold, 2);
  endsequence

  a_busy_low_span: assert property ($rose(track_hold) |=> s_busy_span)
    else $error("busy low span wrong");
  a_track_hold_span: assert property ($rose(track_hold) |-> s_hold_span)
    else $error("track span wrong");
  a_start_needs_select: assert property ($rose(track_hold) |-> !$past(cs_n, 3))
    else $error("start while deselected");
  a_drive_needs_strobes: assert property (!(&data_oe_n) |-> !$past(cs_n, 3) && !$past(rd_n, 3))
    else $error("bus driven without strobes");
  a_low_bits_float: assert property (seq_access && $past(seq_access, 5) |-> &data_oe_n[8:0])
    else $error("low bits driven in readback");
  a_channel_matches: assert property (s_conv_end |-> data_out[15:12] == {conv_diff, conv_mux_addr})
    else $error("channel field wrong");
  a_word_steady: assert property (s_conv_end |-> $stable(data_out)[*3])
    else $error("result word moved");
  a_shutdown_idle: assert property (shutdown_light || shutdown_deep |-> busy && !track_hold)
    else $error("busy low in shutdown");
  a_light_depth: assert property ($rose(shutdown_light) |-> !$past(cs_n, 3) && !$past(power_down_n, 3))
    else $error("light shutdown wrong");
  a_deep_depth: assert property ($rose(shutdown_deep) |-> $past(cs_n, 3) && !$past(power_down_n, 3))
    else $error("deep shutdown wrong");
  a_idle_after_reset: assert property ($rose(rstn) |-> busy)
    else $error("busy low after reset");
endmodule

bind apc_adc_port apc_adc_port_asserts #(.RES_BITS(RES_BITS)) i_apc_adc_port_asserts (
  .clk(clk), .rstn(rstn), .cs_n(cs_n), .rd_n(rd_n), .power_down_n(power_down_n),
  .seq_access(seq_access), .data_out(data_out), .data_oe_n(data_oe_n), .busy(busy),
  .track_hold(track_hold), .conv_diff(conv_diff), .conv_mux_addr(conv_mux_addr),
  .shutdown_light(shutdown_light), .shutdown_deep(shutdown_deep)
);
`default_nettype wire

// File: dv/apc_core_model.sv
// Behavioural converter core that holds one code for each conversion.
`timescale 1ns/1ps
`default_nettype none
module apc_core_model
  import apc_pkg::*;
(
  // Clock
  input  wire logic                clk,
  // Core control
  input  wire logic                track_hold,
  input  wire logic [RESULT_W-1:0] next_code,
  output logic      [RESULT_W-1:0] adc_code
);
  logic                th_reg;
  logic [RESULT_W-1:0] code_reg;

  always_ff @(posedge clk)
  begin
    th_reg <= track_hold;
    if (track_hold && !th_reg)
    begin
      code_reg <= next_code;
    end
  end

  // Outside a conversion the code is meaningless, so a stale value must not look valid.
  assign adc_code = track_hold ? code_reg : ~code_reg;
endmodule
`default_nettype wire

// File: dv/test_adc_conversion_parallel_port.sv
// Self-checking bench for the converter port.
`timescale 1ns/1ps
`default_nettype none
module test_adc_conversion_parallel_port;
  import apc_pkg::*;
  `define CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
    $display("CHECK FAILED %0t %s", $time, msg); end end

  logic                clk, rstn, cs_n, rd_n, cst_n, pd_n, pol, gain, diff, seq_acc, seq_wr_n;
  logic                busy, th, c_diff, c_pol, c_gain, sd_light, sd_deep;
  logic [2:0]          addr, c_addr;
  logic [RESULT_W-1:0] adc_code, next_code;
  logic [WORD_W-1:0]   data_out, data_oe_n;
  logic [WORD_W-1:0]   exp_q[$];
  logic [16:0]         lfsr;
  logic [5:0]          sv[3];
  int                  n_errors, cmp_count;

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  apc_adc_port i_apc_adc_port (.clk(clk), .rstn(rstn), .cs_n(cs_n), .rd_n(rd_n),
    .conversion_start_n(cst_n), .power_down_n(pd_n), .polarity_select(pol), .gain_select(gain),
    .diff_in(diff), .addr_in(addr), .seq_access(seq_acc), .seq_wr_n(seq_wr_n), .data_out(data_out),
    .data_oe_n(data_oe_n), .busy(busy), .adc_code(adc_code), .track_hold(th), .conv_diff(c_diff),
    .conv_mux_addr(c_addr), .conv_polarity(c_pol), .conv_gain(c_gain), .shutdown_light(sd_light),
    .shutdown_deep(sd_deep));

  apc_core_model i_apc_core_model (.clk(clk), .track_hold(th), .next_code(next_code), .adc_code(adc_code));

  function automatic logic [16:0] lfsr_next(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // A second start pulse inside the conversion must be dropped, not queued.
  task automatic convert(input logic [11:0] code, input logic [5:0] cfg, input bit again);
    {diff, addr, pol, gain} = cfg;
    next_code = code;
    exp_q.push_back({cfg[5:2], cfg[1] ? code ^ 12'h800 : code});
    tick(1);
    cst_n = 1'b0;
    tick(3);
    cst_n = 1'b1;
    for (int i = 0; i < 6 && busy; i++) tick(1);
    `CHK({c_diff, c_addr, c_pol, c_gain}, cfg, "latched config")
    if (again)
    begin
      cst_n = 1'b0;
      tick(3);
      cst_n = 1'b1;
    end
    for (int i = 0; i < 20 && !busy; i++) tick(1);
    tick(4);
  endtask

  // Read strobe tied to start: the low level shows the old word and starts the next conversion.
  task automatic tied_read(input logic [11:0] code, input logic [5:0] cfg, input logic [15:0] old_w,
                           input bit pulse);
    {diff, addr, pol, gain} = cfg;
    next_code = code;
    exp_q.push_back({cfg[5:2], cfg[1] ? code ^ 12'h800 : code});
    tick(1);
    {rd_n, cst_n} = 2'b00;
    tick(4);
    `CHK({data_out, data_oe_n, busy}, {old_w, 16'h0000, 1'b0}, "tied strobes old word")
    if (pulse) {rd_n, cst_n} = 2'b11;
    for (int i = 0; i < 20 && !busy; i++) tick(1);
    {rd_n, cst_n} = 2'b11;
    tick(4);
  endtask

  initial
  begin : monitor
    logic [WORD_W-1:0] exp_w;
    bit                conv;
    conv = 1'b0;
    forever
    begin
      @(posedge clk);
      #5;
      if (th === 1'b1) conv = 1'b1;
      if (conv && th === 1'b0 && busy === 1'b1)
      begin
        conv = 1'b0;
        if (exp_q.size() == 0) `CHK(1'b1, 1'b0, "unexpected result")
        else
        begin
          exp_w = exp_q.pop_front();
          `CHK(data_out, exp_w, "result word")
          if (!cs_n && !rd_n) `CHK(data_oe_n, 16'h0000, "bus not driven")
        end
      end
    end
  end

  initial
  begin
    #(4000 * 50);
    n_errors++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    wrap_up();
  end

  initial
  begin
    n_errors = 0;
    cmp_count = 0;
    lfsr = 17'h1239d;
    {rstn, cs_n, rd_n, cst_n, pd_n, pol, gain, diff, seq_acc, seq_wr_n} = 10'h1e1;
    addr = 3'h0;
    next_code = 12'h000;
    tick(5);
    `CHK(busy, 1'b1, "busy in reset")
    `CHK(data_oe_n, 16'hffff, "bus in reset")
    rstn = 1'b1;
    tick(2);
    cs_n = 1'b0;
    rd_n = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      lfsr = lfsr_next(lfsr);
      convert(i < 4 ? 12'(12'h7ff + i) ^ 12'(i[0] * 12'hfff) : lfsr[16:5], {4'(i), lfsr[1:0]}, i == 5);
    end
    $display("test strobes_low done");
    rd_n = 1'b1;
    tick(5);
    `CHK(data_oe_n, 16'hffff, "bus driven without read")
    convert(lfsr[11:0], lfsr[5:0], 1'b0);
    rd_n = 1'b0;
    tick(4);
    `CHK(data_oe_n, 16'h0000, "bus not driven on read")
    cs_n = 1'b1;
    tick(4);
    `CHK(data_oe_n, 16'hffff, "bus driven while deselected")
    rd_n = 1'b1;
    cst_n = 1'b0;
    tick(3);
    cst_n = 1'b1;
    tick(4);
    `CHK({busy, th}, 2'b10, "start while deselected")
    tick(12);
    $display("test read_strobe done");
    cs_n = 1'b0;
    pd_n = 1'b0;
    tick(6);
    `CHK({sd_light, sd_deep, busy}, 3'b101, "light shutdown")
    pd_n = 1'b1;
    tick(2);
    cst_n = 1'b0;
    tick(3);
    cst_n = 1'b1;
    tick(4);
    `CHK({busy, th}, 2'b10, "start during wake")
    cs_n = 1'b1;
    tick(3);
    pd_n = 1'b0;
    tick(6);
    `CHK({sd_light, sd_deep, busy}, 3'b011, "deep shutdown")
    pd_n = 1'b1;
    cs_n = 1'b0;
    tick(10);
    convert(12'h800, 6'h3f, 1'b0);
    $display("test shutdown done");
    tied_read(12'h5a5, 6'h10, 16'hf000, 1'b0);
    tied_read(12'h0f3, 6'h2b, 16'h45a5, 1'b1);
    tied_read(12'h3c1, 6'h07, 16'ha8f3, 1'b1);
    $display("test tied_strobes done");
    sv = '{6'h2a, 6'h15, 6'h33};
    rd_n = 1'b1;
    seq_acc = 1'b1;
    tick(5);
    for (int i = 0; i < 3; i++)
    begin
      {diff, addr, pol, gain} = sv[i];
      seq_wr_n = 1'b0;
      tick(3);
      seq_wr_n = 1'b1;
      tick(3);
    end
    seq_acc = 1'b0;
    tick(4);
    seq_acc = 1'b1;
    tick(6);
    for (int i = 0; i < 3; i++)
    begin
      rd_n = 1'b0;
      tick(4);
      `CHK(data_out[15:9], {sv[i], i == 2}, "status word")
      `CHK(data_oe_n, 16'h01ff, "readback drive")
      rd_n = 1'b1;
      tick(4);
    end
    seq_acc = 1'b0;
    tick(8);
    $display("test readback done");
    `CHK(exp_q.size(), 0, "results missing")
    wrap_up();
  end
endmodule
`default_nettype wire

// File: inc/apc_pkg.sv
// Shared constants, field layout, timing counts and state codes for the converter port.
//
// Function
// - Read word: 12-bit result plus 4-bit channel
// - Drive data only while select and read low
// - Polarity low: straight binary result code
// - Polarity high: two's complement result code
// - Readback shows 7-bit status on upper pins
// - Readback keeps nine lower pins undriven
// - Conversion timed internally, under 650 ns
// - Acquisition 150 ns, start every 800 ns
// - Light shutdown wake takes 200 ns
// - Power-down low means shutdown
// - Select level picks light or deep shutdown
// - Falling start with select low begins conversion
// - Starts ignored until current conversion ends
// - Busy low for the whole conversion
// - Strobes held low: outputs follow, capture on busy
// - Select only: outputs float until read low
// - Tied strobes: old result, then new on busy
// - Channel field shows address used by conversion
// - Status holds six stored bits plus end flag
// - Status bit zero marks last sequence location
package apc_pkg;

  localparam int CLK_PERIOD_NS = 50;

  // Conversion, acquisition and light-shutdown wake times in nanoseconds.
  localparam int CONV_TYP_NS  = 550;
  localparam int CONV_MAX_NS  = 650;
  localparam int ACQ_NS       = 150;
  localparam int THROUGHPUT_NS = 800;
  localparam int NAP_WAKE_NS  = 200;

  localparam int CONV_CYC     = CONV_TYP_NS / CLK_PERIOD_NS;
  localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int ACQ_CYC      = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int THRU_CYC     = THROUGHPUT_NS / CLK_PERIOD_NS;
  localparam int NAP_WAKE_CYC = (NAP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Conversion counter points: the result is queued here and the deliver phase starts here.
  localparam logic [3:0] CONV_PUSH_AT = 4'(CONV_CYC - 3);
  localparam logic [3:0] CONV_END_AT  = 4'(CONV_CYC - 2);

  // Output word layout.
  localparam int WORD_W      = 16;
  localparam int RESULT_W    = 12;
  localparam int DIFF_POS    = 15;
  localparam int ADDR_MSB    = 14;
  localparam int ADDR_LSB    = 12;
  localparam int STATUS_LSB  = 9;
  localparam int STATUS_W    = 7;
  localparam int CFG_W       = 6;
  localparam int LOW_FLOAT_W = 9;

  // Sequencer memory shape.
  localparam int SEQ_DEPTH = 16;
  localparam int SEQ_AW    = 4;

  // Synchroniser bit positions of the sampled pins.
  localparam int SY_CS   = 0;
  localparam int SY_RD   = 1;
  localparam int SY_CONV = 2;
  localparam int SY_PD   = 3;
  localparam int SY_POL  = 4;
  localparam int SY_GAIN = 5;
  localparam int SY_DIFF = 6;
  localparam int SY_A0   = 7;
  localparam int SY_SEQ  = 10;
  localparam int SY_WR   = 11;
  localparam int SY_W    = 12;

  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_CONV    = 3'b001,
    ST_DELIVER = 3'b010,
    ST_SEQ     = 3'b011,
    ST_POWER_DOWN_N    = 3'b100
  } apc_state_t;

endpackage

// File: logic/apc_adc_port.sv
// Conversion control, result buffering, sequencer readback and parallel output of the converter port.
`timescale 1ns/1ps
`default_nettype none
module apc_adc_port
  import apc_pkg::*;
#(
  parameter int RES_BITS = 12
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rstn,
  // Host control pins
  input  wire logic                cs_n,
  input  wire logic                rd_n,
  input  wire logic                conversion_start_n,
  input  wire logic                power_down_n,
  // Configuration pins
  input  wire logic                polarity_select,
  input  wire logic                gain_select,
  input  wire logic                diff_in,
  input  wire logic [2:0]          addr_in,
  // Sequencer access pins
  input  wire logic                seq_access,
  input  wire logic                seq_wr_n,
  // Parallel data bus
  output logic      [WORD_W-1:0]   data_out,
  output logic      [WORD_W-1:0]   data_oe_n,
  output logic                     busy,
  // Converter core
  input  wire logic [RESULT_W-1:0] adc_code,
  output logic                     track_hold,
  output logic                     conv_diff,
  output logic      [2:0]          conv_mux_addr,
  output logic                     conv_polarity,
  output logic                     conv_gain,
  // Power state
  output logic                     shutdown_light,
  output logic                     shutdown_deep
);

  initial
  begin
    if (RES_BITS != 12 && RES_BITS != 10)
      $error("apc_adc_port: RES_BITS must be 12 or 10");
    if (CONV_CYC + 1 > CONV_MAX_CYC || CONV_CYC + 1 + ACQ_CYC > THRU_CYC)
      $error("apc_adc_port: conversion timing exceeds its limits");
  end

  // The narrow variant keeps the upper result bits and forces the dropped ones to zero.
  localparam logic [RESULT_W-1:0] RES_MASK = {RESULT_W{1'b1}} << (RESULT_W - RES_BITS);

  // Offset-binary core code to output code; bipolar only flips the sign bit.
  function automatic logic [RESULT_W-1:0] encode_result(input logic [RESULT_W-1:0] code,
                                                        input logic bipolar);
    logic [RESULT_W-1:0] r;
    r = code & RES_MASK;
    if (bipolar)
      r[RESULT_W-1] = ~r[RESULT_W-1];
    return r;
  endfunction

  // Every pin is foreign to clk, so all pass two flip-flops before use.
  // Reset loads each pin's idle level; the sequencer access pin idles low, so no false access follows reset.
  logic [SY_W-1:0] sync1_reg;
  logic [SY_W-1:0] sync2_reg;
  logic [SY_W-1:0] prev_reg;
  logic [SY_W-1:0] pins_raw;

  assign pins_raw = {seq_wr_n, seq_access, addr_in, diff_in, gain_select,
                     polarity_select, power_down_n, conversion_start_n, rd_n, cs_n};

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_reg <= 12'hbff;
      sync2_reg <= 12'hbff;
      prev_reg  <= 12'hbff;
    end
    else
    begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  logic       s_cs_n;
  logic       s_rd_n;
  logic       s_pd_n;
  logic       s_seq;
  logic [5:0] s_cfg;
  logic       start_fall;
  logic       wr_rise;
  logic       rd_rise;
  logic       seq_change;
  logic       drive;

  assign s_cs_n     = sync2_reg[SY_CS];
  assign s_rd_n     = sync2_reg[SY_RD];
  assign s_pd_n     = sync2_reg[SY_PD];
  assign s_seq      = sync2_reg[SY_SEQ];
  // Stored configuration order: diff, address[2:0], polarity, gain.
  assign s_cfg      = {sync2_reg[SY_DIFF], sync2_reg[SY_A0+2:SY_A0], sync2_reg[SY_POL], sync2_reg[SY_GAIN]};
  assign start_fall = prev_reg[SY_CONV] && !sync2_reg[SY_CONV];
  assign wr_rise    = !prev_reg[SY_WR] && sync2_reg[SY_WR];
  assign rd_rise    = !prev_reg[SY_RD] && s_rd_n;
  assign seq_change = prev_reg[SY_SEQ] != s_seq;
  assign drive      = !s_cs_n && !s_rd_n;

  apc_state_t  state_reg;
  apc_state_t  state_next;
  logic [3:0]  conv_cnt_reg;
  logic [2:0]  acq_cnt_reg;
  logic [2:0]  wake_cnt_reg;
  logic [5:0]  cfg_reg;
  logic        start_ok;
  logic        push;

  // Two-entry result buffer between the converter and the output register.
  logic [WORD_W-1:0] buf_mem_reg [2];
  logic              buf_wp_reg;
  logic              buf_rp_reg;
  logic [1:0]        buf_cnt_reg;
  logic              buf_in_ready;
  logic              buf_out_valid;
  logic              buf_out_ready;
  logic              pop;
  logic [WORD_W-1:0] push_word;

  assign buf_in_ready  = buf_cnt_reg != 2'h2;
  assign buf_out_valid = buf_cnt_reg != 2'h0;
  // The output register stalls while it shows sequencer status, so nothing queued is overwritten.
  assign buf_out_ready = state_reg != ST_SEQ;
  assign pop           = buf_out_valid && buf_out_ready;
  assign push          = state_reg == ST_CONV && conv_cnt_reg == CONV_PUSH_AT && buf_in_ready;

  // Channel field carries the address latched for this very conversion.
  assign push_word = {cfg_reg[5], cfg_reg[4:2], encode_result(adc_code, cfg_reg[1])};

  // A start is taken only when idle, selected, rested and with room for its result.
  assign start_ok = state_reg == ST_IDLE && !s_cs_n && start_fall
                    && acq_cnt_reg == 3'h0 && wake_cnt_reg == 3'h0 && buf_in_ready;

  always_comb
  begin
    state_next = state_reg;
    if (!s_pd_n)
      state_next = ST_POWER_DOWN_N;
    else
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          if (s_seq)
            state_next = ST_SEQ;
          else if (start_ok)
            state_next = ST_CONV;
        end
        ST_CONV:
        begin
          if (conv_cnt_reg == CONV_END_AT)
            state_next = ST_DELIVER;
        end
        ST_DELIVER:
        begin
          if (!buf_out_valid)
            state_next = ST_IDLE;
        end
        ST_SEQ:
        begin
          if (!s_seq)
            state_next = ST_IDLE;
        end
        ST_POWER_DOWN_N:
          state_next = ST_IDLE;
        default:
          state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      conv_cnt_reg <= 4'h0;
    else if (state_reg == ST_CONV)
      conv_cnt_reg <= conv_cnt_reg + 4'h1;
    else
      conv_cnt_reg <= 4'h0;
  end

  // Configuration is frozen at the start so a pin change mid-conversion cannot corrupt the field.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cfg_reg <= 6'h00;
    else if (start_ok && s_pd_n && !s_seq)
      cfg_reg <= s_cfg;
  end

  // Acquisition rest after each conversion keeps the throughput within one start per 800 ns.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      acq_cnt_reg <= 3'h0;
    else if (state_reg == ST_DELIVER && state_next == ST_IDLE)
      acq_cnt_reg <= 3'(ACQ_CYC);
    else if (acq_cnt_reg != 3'h0)
      acq_cnt_reg <= acq_cnt_reg - 3'h1;
  end

  // Wake time after shutdown; deep sleep uses the same count, the reference wait is the host's.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      wake_cnt_reg <= 3'h0;
    else if (state_reg == ST_POWER_DOWN_N)
      wake_cnt_reg <= 3'(NAP_WAKE_CYC);
    else if (wake_cnt_reg != 3'h0)
      wake_cnt_reg <= wake_cnt_reg - 3'h1;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      buf_wp_reg  <= 1'b0;
      buf_rp_reg  <= 1'b0;
      buf_cnt_reg <= 2'h0;
    end
    else
    begin
      if (push)
        buf_wp_reg <= ~buf_wp_reg;
      if (pop)
        buf_rp_reg <= ~buf_rp_reg;
      if (push && !pop)
        buf_cnt_reg <= buf_cnt_reg + 2'h1;
      else if (pop && !push)
        buf_cnt_reg <= buf_cnt_reg - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      buf_mem_reg[0] <= WORD_RESET;
      buf_mem_reg[1] <= WORD_RESET;
    end
    else if (push)
      buf_mem_reg[buf_wp_reg] <= push_word;
  end

  // Last finished result; it stays put through a new conversion until that one completes.
  logic [WORD_W-1:0] result_reg;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      result_reg <= WORD_RESET;
    else if (pop)
      result_reg <= buf_mem_reg[buf_rp_reg];
  end

  // Sequencer pointer, last written location and stored configuration.
  logic [SEQ_AW-1:0] seq_ptr_reg;
  logic [SEQ_AW-1:0] seq_last_reg;
  logic              seq_we;
  logic [CFG_W-1:0]  seq_rdata;
  logic              eos_flag;

  assign seq_we   = state_reg == ST_SEQ && wr_rise && s_rd_n;
  assign eos_flag = seq_ptr_reg == seq_last_reg;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      seq_ptr_reg <= '0;
    else if (seq_change)
      seq_ptr_reg <= '0;
    else if (seq_we || (state_reg == ST_SEQ && rd_rise))
      seq_ptr_reg <= seq_ptr_reg + 4'h1;                         // wraps after 16 locations
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      seq_last_reg <= 4'hf;
    else if (seq_we)
      seq_last_reg <= seq_ptr_reg;
  end

  apc_seq_mem #(
    .WIDTH (CFG_W),
    .DEPTH (SEQ_DEPTH),
    .AW    (SEQ_AW)
  ) u_seq_mem (
    .clk   (clk),
    .rstn  (rstn),
    .we    (seq_we),
    .waddr (seq_ptr_reg),
    .wdata (s_cfg),
    .raddr (seq_ptr_reg),
    .rdata (seq_rdata)
  );

  // Output pins are registered; enables are low while a pin is driven.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      data_out  <= WORD_RESET;
      data_oe_n <= 16'hffff;
    end
    else if (state_reg == ST_SEQ)
    begin
      data_out  <= {seq_rdata, eos_flag, {LOW_FLOAT_W{1'b0}}};
      data_oe_n <= {{STATUS_W{~drive}}, {LOW_FLOAT_W{1'b1}}};
    end
    else
    begin
      data_out  <= result_reg;
      data_oe_n <= {WORD_W{~drive}};
    end
  end

  // Busy follows the state a cycle late so the new word is already on the pins when it rises.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      busy <= 1'b1;
    else
      busy <= state_reg == ST_IDLE || state_reg == ST_POWER_DOWN_N || !s_pd_n;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      shutdown_light <= 1'b0;
      shutdown_deep  <= 1'b0;
      track_hold     <= 1'b0;
    end
    else
    begin
      shutdown_light <= state_next == ST_POWER_DOWN_N && !s_cs_n;
      shutdown_deep  <= state_next == ST_POWER_DOWN_N && s_cs_n;
      track_hold     <= state_next == ST_CONV;
    end
  end

  assign conv_diff     = cfg_reg[5];
  assign conv_mux_addr = cfg_reg[4:2];
  assign conv_polarity = cfg_reg[1];
  assign conv_gain     = cfg_reg[0];

endmodule
`default_nettype wire

// File: logic/apc_seq_mem.sv
// Small single-port-write, registered-read memory holding the sequencer locations.
`timescale 1ns/1ps
`default_nettype none
module apc_seq_mem #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Write side
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // Read side
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  initial
  begin
    if (DEPTH > (1 << AW) || WIDTH < 1)
      $error("apc_seq_mem: depth does not fit the address width");
  end

  // The array has no reset, like the part it stands for; contents survive shutdown.
  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata <= '0;
    else
      rdata <= mem[raddr];
  end

endmodule
`default_nettype wire
